// ### design/ebm_pkg.sv
package ebm_pkg;
    localparam int DATA_W  = 16;
    localparam int ADDR_W  = 24;
    localparam int CS_W    = 4;
    localparam int SDR_A_W = 13;
    localparam int BANK_W  = 2;

    // Chip select shared by both controllers
    localparam int SDR_CS = 1;
    localparam logic [CS_W-1:0] CS_IDLE = 4'hf;

    // SDRAM address placement on the address pins
    localparam int SDR_LO_PIN = 2;
    localparam int SDR_LO_W   = 10;
    localparam int SDR_A10    = 10;
    localparam int SDR_HI_PIN = 13;
    localparam int SDR_HI_BIT = 11;
    localparam int SDR_HI_W   = 2;
    localparam int SMC_HI_PIN = 15;
    localparam int SMC_A12    = 12;

    // Idle cycles between two owners, lets data drivers float
    localparam logic [3:0] TURN_CYC = 4'h1;

    typedef struct packed {
        logic              valid;
        logic [CS_W-1:0]   cs_n;
        logic [ADDR_W-1:0] addr;  // Bit 0 may carry lower byte select
        logic              oe_n;
        logic              rd_n;
        logic              we_n;
        logic              ub_n;  // Upper byte write or select
        logic [DATA_W-1:0] dout;
        logic              doe;
    } ebm_smc_req_t;

    typedef struct packed {
        logic               valid;
        logic               refresh;
        logic               cs_n;
        logic [SDR_A_W-1:0] addr;
        logic [BANK_W-1:0]  bank;
        logic               cke;
        logic               ras_n;
        logic               cas_n;
        logic               we_n;
        logic               dqm1_n;
        logic [DATA_W-1:0]  dout;
        logic               doe;
    } ebm_sdr_req_t;

    typedef struct packed {
        logic [CS_W-1:0]   cs_n;
        logic [ADDR_W-1:0] addr;
        logic              oe_n;
        logic              we_n;
        logic              ub_n;
        logic              sdram_addr_bit10;
        logic [BANK_W-1:0] bank;
        logic              cke;
        logic              sd_we_n;
        logic              ras_n;
        logic              cas_n;
        logic [DATA_W-1:0] dout;
        logic              doe;
    } ebm_pins_t;

    localparam ebm_pins_t PINS_RST = '{cs_n: CS_IDLE, oe_n: 1'h1, we_n: 1'h1,
                                       ub_n: 1'h1, sd_we_n: 1'h1, ras_n: 1'h1,
                                       cas_n: 1'h1, default: '0};

    typedef enum logic [1:0] {OWN_IDLE, OWN_SMC, OWN_SDR, OWN_TURN} ebm_own_t;
endpackage

// ### design/ebm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ebm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         en_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } ebm_sync_st_t;

    ebm_sync_st_t s_reg;
    ebm_sync_st_t s_next;

    // First stage is read by the second stage only
    always_comb begin
        s_next.meta = d_i;
        s_next.q    = s_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else if (en_i) begin
            s_reg <= s_next;
        end
    end

    assign q_o = s_reg.q;
endmodule
`default_nettype wire

// ### design/ebm_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module ebm_arbiter (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire ebm_pkg::ebm_smc_req_t smc_i,
    input  wire ebm_pkg::ebm_sdr_req_t sdr_i,
    output var  ebm_pkg::ebm_own_t     own_o,
    output var  logic                  ref_gnt_o
);
    typedef struct packed {
        ebm_pkg::ebm_own_t own;
        logic              last_sdr;
        logic [3:0]        turn_cnt;
        logic              ref_gnt;
    } ebm_arb_st_t;

    ebm_arb_st_t a_reg;
    ebm_arb_st_t a_next;
    logic        smc_w;
    logic        sdr_w;

    // Refresh needs only dedicated lines and the shared select, so it never enters arbitration
    assign smc_w = smc_i.valid;
    assign sdr_w = sdr_i.valid && !sdr_i.refresh;

    // One owner at a time, the loser waits; idle gap between owners
    always_comb begin
        a_next = a_reg;
        case (a_reg.own)
            ebm_pkg::OWN_IDLE: begin
                if (smc_w && (!sdr_w || a_reg.last_sdr)) begin
                    a_next.own      = ebm_pkg::OWN_SMC;
                    a_next.last_sdr = 1'h0;
                end else if (sdr_w) begin
                    a_next.own      = ebm_pkg::OWN_SDR;
                    a_next.last_sdr = 1'h1;
                end
            end
            ebm_pkg::OWN_SMC: begin
                if (!smc_w) begin
                    a_next.own      = ebm_pkg::OWN_TURN;
                    a_next.turn_cnt = ebm_pkg::TURN_CYC - 4'h1;
                end
            end
            ebm_pkg::OWN_SDR: begin
                if (!sdr_w) begin
                    a_next.own      = ebm_pkg::OWN_TURN;
                    a_next.turn_cnt = ebm_pkg::TURN_CYC - 4'h1;
                end
            end
            ebm_pkg::OWN_TURN: begin
                if (a_reg.turn_cnt == 4'h0) begin
                    a_next.own = ebm_pkg::OWN_IDLE;
                end else begin
                    a_next.turn_cnt = a_reg.turn_cnt - 4'h1;
                end
            end
            default: begin
                a_next.own = ebm_pkg::OWN_IDLE;
            end
        endcase
        // Refresh runs beside static work unless that work sits on the shared select
        a_next.ref_gnt = sdr_i.valid && sdr_i.refresh
                         && (a_next.own != ebm_pkg::OWN_SDR)
                         && !(a_next.own == ebm_pkg::OWN_SMC
                              && !smc_i.cs_n[ebm_pkg::SDR_CS]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_reg <= '{own: ebm_pkg::OWN_IDLE, default: '0};
        end else if (ce_i) begin
            a_reg <= a_next;
        end
    end

    assign own_o     = a_reg.own;
    assign ref_gnt_o = a_reg.ref_gnt;

    property p_sdr_hold;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && a_reg.own == ebm_pkg::OWN_SDR && sdr_w) |=> a_reg.own == ebm_pkg::OWN_SDR;
    endproperty
    a_sdr_hold: assert property (p_sdr_hold) else $error("sdram owner lost pins early");

    property p_turn;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && a_reg.own == ebm_pkg::OWN_SMC && !smc_w)
            |=> a_reg.own == ebm_pkg::OWN_TURN;
    endproperty
    a_turn: assert property (p_turn) else $error("no float gap after static owner");
endmodule
`default_nettype wire

// ### design/ebm_pin_mux.sv
`timescale 1ns/100ps
`default_nettype none
module ebm_pin_mux (
    input  wire logic                       ref_clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       ce_i,
    input  wire logic                       link_clk_i,
    input  wire ebm_pkg::ebm_smc_req_t      smc_req_i,
    input  wire ebm_pkg::ebm_sdr_req_t      sdr_req_i,
    output var  logic                       smc_gnt_o,
    output var  logic                       sdr_gnt_o,
    output var  logic                       sdr_ref_gnt_o,
    output var  logic                       pin_ack_o,
    output var  logic [ebm_pkg::DATA_W-1:0] rd_data_o,
    output var  logic                       ext_wait_o,
    input  wire logic [ebm_pkg::DATA_W-1:0] data_i,
    input  wire logic                       external_wait_n_i,
    output var  ebm_pkg::ebm_pins_t         pins_o
);
    // Bound on one pin-word handshake, in system clock cycles
    localparam int XFER_MAX_CYC = 40;

    typedef struct packed {
        ebm_pkg::ebm_pins_t          cur;
        ebm_pkg::ebm_pins_t          send;
        logic                        req_tgl;
        logic                        pend;
        logic                        ack_seen;
        logic                        pin_ack;
        logic                        smc_gnt;
        logic                        sdr_gnt;
        logic                        ref_gnt;
        logic                        wait_req;
        logic [ebm_pkg::DATA_W-1:0]  rd_data;
    } ebm_ref_st_t;

    typedef struct packed {
        ebm_pkg::ebm_pins_t          pins;
        logic                        req_seen;
        logic                        ack_tgl;
        logic [ebm_pkg::DATA_W-1:0]  rd_hold;
    } ebm_lnk_st_t;

    ebm_ref_st_t                r_reg;
    ebm_ref_st_t                r_next;
    ebm_lnk_st_t                l_reg;
    ebm_lnk_st_t                l_next;
    ebm_pkg::ebm_own_t          own;
    logic                       ref_gnt;
    logic                       ack_s;
    logic                       wait_s;
    logic                       req_s;
    logic                       rst_l;
    logic [ebm_pkg::DATA_W-1:0] data_s;

    // Ownership and refresh permission
    ebm_arbiter u_arb (
        .clk_i     (ref_clk_i),
        .rst_i     (sys_rst_i),
        .ce_i      (ce_i),
        .smc_i     (smc_req_i),
        .sdr_i     (sdr_req_i),
        .own_o     (own),
        .ref_gnt_o (ref_gnt)
    );

    // Wait pin is asynchronous; two stages before use
    ebm_sync #(.W(1)) u_wait_sync (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .en_i  (ce_i),
        .d_i   (~external_wait_n_i),
        .q_o   (wait_s)
    );

    // Link acknowledge toggle into the system domain
    ebm_sync #(.W(1)) u_ack_sync (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .en_i  (ce_i),
        .d_i   (l_reg.ack_tgl),
        .q_o   (ack_s)
    );

    // Reset reaches the link domain through its own stages
    ebm_sync #(.W(1)) u_rst_sync (
        .clk_i (link_clk_i),
        .rst_i (1'h0),
        .en_i  (1'h1),
        .d_i   (sys_rst_i),
        .q_o   (rst_l)
    );

    // Request toggle into the link domain
    ebm_sync #(.W(1)) u_req_sync (
        .clk_i (link_clk_i),
        .rst_i (rst_l),
        .en_i  (1'h1),
        .d_i   (r_reg.req_tgl),
        .q_o   (req_s)
    );

    // Data pins sampled on the link clock
    ebm_sync #(.W(ebm_pkg::DATA_W)) u_data_sync (
        .clk_i (link_clk_i),
        .rst_i (rst_l),
        .en_i  (1'h1),
        .d_i   (data_i),
        .q_o   (data_s)
    );

    // Compose the pin word and run the handshake toward the link side
    always_comb begin
        r_next         = r_reg;
        r_next.pin_ack = 1'h0;
        // Strobes idle, address and data bits hold their last value
        r_next.cur         = r_reg.cur;
        r_next.cur.cs_n    = ebm_pkg::CS_IDLE;
        r_next.cur.oe_n    = 1'h1;
        r_next.cur.we_n    = 1'h1;
        r_next.cur.ub_n    = 1'h1;
        r_next.cur.cke     = 1'h0;
        r_next.cur.sd_we_n = 1'h1;
        r_next.cur.ras_n   = 1'h1;
        r_next.cur.cas_n   = 1'h1;
        r_next.cur.doe     = 1'h0;
        case (own)
            ebm_pkg::OWN_SMC: begin
                // Static side drives every select and all 24 address bits
                r_next.cur.cs_n = smc_req_i.cs_n;
                r_next.cur.addr = smc_req_i.addr;
                r_next.cur.oe_n = smc_req_i.oe_n & smc_req_i.rd_n;
                r_next.cur.we_n = smc_req_i.we_n;
                r_next.cur.ub_n = smc_req_i.ub_n;
                r_next.cur.dout = smc_req_i.dout;
                r_next.cur.doe  = smc_req_i.doe;
            end
            ebm_pkg::OWN_SDR: begin
                // Pins 0, 1, 12, 15-23 stay static
                r_next.cur.cs_n[ebm_pkg::SDR_CS] = sdr_req_i.cs_n;
                r_next.cur.addr[ebm_pkg::SDR_LO_PIN +: ebm_pkg::SDR_LO_W] =
                    sdr_req_i.addr[0 +: ebm_pkg::SDR_LO_W];
                r_next.cur.sdram_addr_bit10 = sdr_req_i.addr[ebm_pkg::SDR_A10];
                r_next.cur.addr[ebm_pkg::SDR_HI_PIN +: ebm_pkg::SDR_HI_W] =
                    sdr_req_i.addr[ebm_pkg::SDR_HI_BIT +: ebm_pkg::SDR_HI_W];
                r_next.cur.bank    = sdr_req_i.bank;
                r_next.cur.cke     = sdr_req_i.cke;
                r_next.cur.ras_n   = sdr_req_i.ras_n;
                r_next.cur.cas_n   = sdr_req_i.cas_n;
                r_next.cur.sd_we_n = sdr_req_i.we_n;
                r_next.cur.ub_n    = sdr_req_i.dqm1_n;
                r_next.cur.dout    = sdr_req_i.dout;
                r_next.cur.doe     = sdr_req_i.doe;
            end
            default: begin
            end
        endcase
        // Refresh uses only dedicated lines and the shared select
        if (ref_gnt) begin
            r_next.cur.cs_n[ebm_pkg::SDR_CS] = sdr_req_i.cs_n;
            r_next.cur.cke     = sdr_req_i.cke;
            r_next.cur.ras_n   = sdr_req_i.ras_n;
            r_next.cur.cas_n   = sdr_req_i.cas_n;
            r_next.cur.sd_we_n = sdr_req_i.we_n;
        end
        // One word in flight; read data is stable once the ack arrives
        if (ack_s != r_reg.ack_seen) begin
            r_next.ack_seen = ack_s;
            r_next.pend     = 1'h0;
            r_next.rd_data  = l_reg.rd_hold;
            r_next.pin_ack  = 1'h1;
        end else if (!r_reg.pend && (r_next.cur != r_reg.send)) begin
            r_next.send    = r_next.cur;
            r_next.req_tgl = ~r_reg.req_tgl;
            r_next.pend    = 1'h1;
        end
        r_next.smc_gnt  = (own == ebm_pkg::OWN_SMC);
        r_next.sdr_gnt  = (own == ebm_pkg::OWN_SDR);
        r_next.ref_gnt  = ref_gnt;
        r_next.wait_req = wait_s;
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            r_reg <= '{cur: ebm_pkg::PINS_RST, send: ebm_pkg::PINS_RST, default: '0};
        end else if (ce_i) begin
            r_reg <= r_next;
        end
    end

    // Link side applies a new word on each request toggle
    always_comb begin
        l_next = l_reg;
        if (req_s != l_reg.req_seen) begin
            l_next.req_seen = req_s;
            l_next.pins     = r_reg.send;
            l_next.rd_hold  = data_s;
            l_next.ack_tgl  = ~l_reg.ack_tgl;
        end
    end

    // Not gated by ce_i: the link domain must finish a started handshake
    always_ff @(posedge link_clk_i) begin
        if (rst_l) begin
            l_reg <= '{pins: ebm_pkg::PINS_RST, default: '0};
        end else begin
            l_reg <= l_next;
        end
    end

    // Every output straight from a flip-flop
    assign pins_o        = l_reg.pins;
    assign smc_gnt_o     = r_reg.smc_gnt;
    assign sdr_gnt_o     = r_reg.sdr_gnt;
    assign sdr_ref_gnt_o = r_reg.ref_gnt;
    assign pin_ack_o     = r_reg.pin_ack;
    assign rd_data_o     = r_reg.rd_data;
    assign ext_wait_o    = r_reg.wait_req;

    property p_gnt_excl;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        !(r_reg.smc_gnt && r_reg.sdr_gnt);
    endproperty
    a_gnt_excl: assert property (p_gnt_excl) else $error("both controllers granted");

    property p_sdr_cs;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (own == ebm_pkg::OWN_SDR)
            |-> (r_next.cur.cs_n[0] && r_next.cur.cs_n[2] && r_next.cur.cs_n[3]);
    endproperty
    a_sdr_cs: assert property (p_sdr_cs) else $error("sdram drove a static select");

    property p_idle_ctrl;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (own == ebm_pkg::OWN_IDLE && !ref_gnt)
            |-> (r_next.cur.cs_n == ebm_pkg::CS_IDLE && r_next.cur.oe_n
                 && r_next.cur.we_n && r_next.cur.ras_n && r_next.cur.cas_n
                 && !r_next.cur.doe);
    endproperty
    a_idle_ctrl: assert property (p_idle_ctrl) else $error("strobe active while idle");

    property p_idle_addr;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (ce_i && own == ebm_pkg::OWN_IDLE) |=> r_reg.cur.addr == $past(r_reg.cur.addr);
    endproperty
    a_idle_addr: assert property (p_idle_addr) else $error("address moved while idle");

    property p_sdr_addr;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (own == ebm_pkg::OWN_SDR)
            |-> (r_next.cur.addr[11:2] == sdr_req_i.addr[9:0]
                 && r_next.cur.sdram_addr_bit10 == sdr_req_i.addr[10]
                 && r_next.cur.addr[14:13] == sdr_req_i.addr[12:11]);
    endproperty
    a_sdr_addr: assert property (p_sdr_addr) else $error("sdram address misplaced");

    property p_sdr_static_hi;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (ce_i && own == ebm_pkg::OWN_SDR)
            |=> (r_reg.cur.addr[23:15] == $past(r_reg.cur.addr[23:15])
                 && r_reg.cur.addr[12] == $past(r_reg.cur.addr[12])
                 && r_reg.cur.addr[1:0] == $past(r_reg.cur.addr[1:0]));
    endproperty
    a_sdr_static_hi: assert property (p_sdr_static_hi) else $error("sdram hit static pin");

    property p_xfer_done;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(r_reg.pend) |-> ##[1:XFER_MAX_CYC] !r_reg.pend;
    endproperty
    a_xfer_done: assert property (p_xfer_done) else $error("pin word never acknowledged");

    property p_link_apply;
        @(posedge link_clk_i) disable iff (rst_l)
        (req_s != l_reg.req_seen) |=> (l_reg.pins == $past(r_reg.send));
    endproperty
    a_link_apply: assert property (p_link_apply) else $error("pins missed offered word");

    // Routing guards for owner changes, refresh, the ack pulse and the wait output
    property p_smc_route;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (own == ebm_pkg::OWN_SMC && !ref_gnt)
            |-> (r_next.cur.cs_n == smc_req_i.cs_n && r_next.cur.addr == smc_req_i.addr);
    endproperty
    a_smc_route: assert property (p_smc_route) else $error("static word misrouted");

    property p_ref_lines;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ref_gnt |-> (own != ebm_pkg::OWN_SDR
                     && r_next.cur.cs_n[ebm_pkg::SDR_CS] == sdr_req_i.cs_n
                     && r_next.cur.ras_n == sdr_req_i.ras_n
                     && r_next.cur.cas_n == sdr_req_i.cas_n);
    endproperty
    a_ref_lines: assert property (p_ref_lines) else $error("refresh misrouted");

    property p_cke_idle;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (own != ebm_pkg::OWN_SDR && !ref_gnt) |-> !r_next.cur.cke;
    endproperty
    a_cke_idle: assert property (p_cke_idle) else $error("sdram clock enable on");

    property p_float;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (own == ebm_pkg::OWN_TURN) |-> !r_next.cur.doe;
    endproperty
    a_float: assert property (p_float) else $error("data driven in turnaround");

    property p_turn_gap;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (ce_i && own == ebm_pkg::OWN_SMC) |=> own != ebm_pkg::OWN_SDR;
    endproperty
    a_turn_gap: assert property (p_turn_gap) else $error("no owner gap");

    property p_ack_pulse;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        (ce_i && r_reg.pin_ack) |=> !r_reg.pin_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("pin ack held too long");

    property p_wait_follow;
        @(posedge ref_clk_i) disable iff (sys_rst_i)
        ce_i |=> r_reg.wait_req == $past(wait_s);
    endproperty
    a_wait_follow: assert property (p_wait_follow) else $error("wait output lags");
endmodule
`default_nettype wire

// ### bench/ebm_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ebm_mem_model (
    input  wire logic                       link_clk_i,
    input  wire ebm_pkg::ebm_pins_t         pins_i,
    input  wire logic                       stall_i,
    output var  logic [ebm_pkg::DATA_W-1:0] data_o,
    output var  logic                       wait_n_o
);
    logic [ebm_pkg::DATA_W-1:0] junk_reg = 16'h0f0f;
    logic                       rd_sel;

    // Memory answers only while selected with output enable low
    assign rd_sel = (pins_i.cs_n != 4'hf) && !pins_i.oe_n;
    // Released bus toggles every cycle, so a stale value never looks right
    always @(posedge link_clk_i) junk_reg <= ~junk_reg;
    assign data_o = rd_sel ? (pins_i.addr[15:0] ^ 16'h5a3c) : junk_reg;
    // Stretch request pulls the wait line low
    assign wait_n_o = !stall_i;
endmodule
`default_nettype wire

// ### bench/ebm_pin_mux_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ebm_pin_mux_bench;
    typedef struct packed {
        ebm_pkg::ebm_pins_t w;
        logic               chk;
        logic [15:0]        rd;
    } ebm_note_t;
    logic                  ref_clk = 1'h0;
    logic                  link_clk = 1'h0;
    logic                  sys_rst = 1'h1;
    logic                  stall = 1'h0;
    logic                  rd = 1'h0;
    logic [15:0]           rd_exp = 16'h0;
    ebm_pkg::ebm_smc_req_t static_memory_controller = '0;
    ebm_pkg::ebm_sdr_req_t sdr = '0;
    ebm_pkg::ebm_pins_t    pins;
    ebm_pkg::ebm_pins_t    last = ebm_pkg::PINS_RST;
    logic [15:0]           rd_data, mem_data, data_bus;
    logic                  smc_gnt, sdr_gnt, ref_gnt, ack, ext_wait, wait_n;
    ebm_note_t             notes[$];
    ebm_note_t             cur;
    int                    fail_count = 0;
    int                    num_checks = 0;
    int                    cyc = 0;

    // Free clocks, link one offset by 3 ns; edges still meet at 48 ns and every 60 ns after
    always #4 ref_clk = ~ref_clk;
    initial #3 forever #15 link_clk = ~link_clk;
    // Data wire level from both drivers
    assign data_bus = pins.doe ? pins.dout : mem_data;

    ebm_pin_mux ebm_pin_mux_i (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .ce_i(1'h1),
        .link_clk_i(link_clk), .smc_req_i(static_memory_controller), .sdr_req_i(sdr), .smc_gnt_o(smc_gnt),
        .sdr_gnt_o(sdr_gnt), .sdr_ref_gnt_o(ref_gnt), .pin_ack_o(ack), .rd_data_o(rd_data),
        .ext_wait_o(ext_wait), .data_i(data_bus), .external_wait_n_i(wait_n), .pins_o(pins));
    ebm_mem_model ebm_mem_model_i (.link_clk_i(link_clk), .pins_i(pins), .stall_i(stall),
        .data_o(mem_data), .wait_n_o(wait_n));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Random fields for an active phase; closing phase drops all strobes
    task automatic set_req(input bit own_sdr, input bit on);
        if (own_sdr) begin
            {sdr.valid, sdr.refresh, sdr.cs_n, sdr.cke} = {2'h2, !on, on};
            if (on) {sdr.addr, sdr.bank, sdr.dout} = 31'($urandom);
            {sdr.ras_n, sdr.cas_n, sdr.we_n, sdr.dqm1_n, sdr.doe} = on ? 5'($urandom) : 5'h1e;
        end else begin
            if (on) begin
                rd = 1'($urandom);
                static_memory_controller.addr = 24'($urandom);
                static_memory_controller.dout = rd ? last.dout : 16'($urandom);
                rd_exp = static_memory_controller.addr[15:0] ^ 16'h5a3c;
            end
            static_memory_controller.valid = 1'h1;
            static_memory_controller.cs_n = on ? ~(4'h1 << $urandom_range(3, 0)) : 4'hf;
            {static_memory_controller.oe_n, static_memory_controller.rd_n} = (on && rd) ? 2'($urandom_range(2, 1)) : 2'h3;
            {static_memory_controller.we_n, static_memory_controller.ub_n, static_memory_controller.doe} = on ? {rd, 1'($urandom), !rd} : 3'h6;
        end
    endtask

    // Expected pin word of the owner; unused pins keep their last level
    task automatic note(input bit own_sdr, input bit chk);
        if (own_sdr) begin
            last.cs_n = 4'hf;
            last.cs_n[ebm_pkg::SDR_CS] = sdr.cs_n;
            {last.addr[14:13], last.sdram_addr_bit10, last.addr[11:2]} = sdr.addr;
            {last.bank, last.cke, last.sd_we_n, last.ras_n, last.cas_n} =
                {sdr.bank, sdr.cke, sdr.we_n, sdr.ras_n, sdr.cas_n};
            {last.oe_n, last.we_n, last.ub_n} = {2'h3, sdr.dqm1_n};
            {last.dout, last.doe} = {sdr.dout, sdr.doe};
        end else begin
            {last.cs_n, last.addr, last.we_n, last.ub_n} = {static_memory_controller.cs_n, static_memory_controller.addr, static_memory_controller.we_n, static_memory_controller.ub_n};
            last.oe_n = static_memory_controller.oe_n & static_memory_controller.rd_n;
            {last.cke, last.sd_we_n, last.ras_n, last.cas_n} = 4'h7;
            {last.dout, last.doe} = {static_memory_controller.dout, static_memory_controller.doe};
        end
        notes.push_back(ebm_note_t'{last, chk, rd_exp});
    endtask

    task automatic wait_ack();
        do @(negedge ref_clk); while (!ack);
    endtask

    // One pin phase, held until the pins confirm it
    task automatic step(input bit own_sdr, input bit on, input bit chk);
        set_req(own_sdr, on);
        note(own_sdr, chk);
        wait_ack();
        check("grants", {smc_gnt, sdr_gnt}, own_sdr ? 2'h1 : 2'h2);
    endtask

    task automatic release_pins(input bit own_sdr);
        if (own_sdr) sdr.valid = 1'h0;
        else static_memory_controller.valid = 1'h0;
        do @(negedge ref_clk); while (smc_gnt || sdr_gnt);
    endtask

    // Each acked word is matched to the oldest note; a spare ack means idle drift
    always @(negedge ref_clk) begin
        if (ack && notes.size() == 0) check("spare ack", 1'h1, 1'h0);
        else if (ack) begin
            cur = notes.pop_front();
            check("selects", pins.cs_n, cur.w.cs_n);
            check("address", pins[50:22], cur.w[50:22]);
            check("sdram pins", pins[21:17], cur.w[21:17]);
            check("strobes", pins[26:18], cur.w[26:18]);
            check("data out", pins[16:0], cur.w[16:0]);
            if (cur.chk) check("read data", rd_data, cur.rd);
        end
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(39));
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'h0;
        repeat (6) @(negedge ref_clk);
        check("idle pins", pins, ebm_pkg::PINS_RST);
        // Both ask together: SDRAM first after reset, static after the turnaround
        set_req(1'h0, 1'h1);
        step(1'h1, 1'h1, 1'h0);
        step(1'h1, 1'h0, 1'h0);
        sdr.valid = 1'h0;
        note(1'h0, 1'h0);
        wait_ack();
        check("late grant", {smc_gnt, sdr_gnt}, 2'h2);
        step(1'h0, 1'h0, rd);
        release_pins(1'h0);
        // Alternating owners, random selects, addresses and directions
        for (int i = 0; i < 12; i++) begin
            step(i[0], 1'h1, 1'h0);
            step(i[0], 1'h0, !i[0] && rd);
            release_pins(i[0]);
        end
        // Refresh with no owner: shared select and dedicated lines only
        {sdr.valid, sdr.refresh, sdr.cs_n, sdr.cke, sdr.ras_n, sdr.cas_n, sdr.we_n} = 7'h69;
        {last.cs_n, last.oe_n, last.we_n, last.ub_n, last.cke} = 8'hdf;
        {last.sd_we_n, last.ras_n, last.cas_n, last.doe} = 4'h8;
        notes.push_back(ebm_note_t'{last, 1'h0, rd_exp});
        wait_ack();
        check("refresh grant", {ref_gnt, smc_gnt, sdr_gnt}, 3'h4);
        sdr.valid = 1'h0;
        {last.cs_n, last.cke, last.ras_n, last.cas_n} = 7'h7b;
        notes.push_back(ebm_note_t'{last, 1'h0, rd_exp});
        wait_ack();
        check("refresh grant", {ref_gnt, smc_gnt, sdr_gnt}, 3'h0);
        // Memory stretches, then lets go
        stall = 1'h1;
        repeat (12) @(negedge ref_clk);
        check("wait", ext_wait, 1'h1);
        stall = 1'h0;
        repeat (12) @(negedge ref_clk);
        check("wait", ext_wait, 1'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
